// ---- inc/udq_pkg.sv ----
/*
  Package of the packet DMA queue state block: register offsets, write masks, field positions,
  reset values, bus answer latency and the update and state carriers.
  Assumes a 32-bit Avalon-MM register port with byte addresses.
*/
package udq_pkg;

  localparam int unsigned UDQ_ADDR_W = 8;
  localparam int unsigned UDQ_DATA_W = 32;
  localparam int unsigned UDQ_CHANS = 4;
  localparam int unsigned UDQ_TALLY_W = 16;
  localparam int unsigned UDQ_PTR_W = 30;
  localparam int unsigned UDQ_PTR_LSB = 2;
  localparam int unsigned UDQ_INPKT_BIT = 0;
  localparam int unsigned UDQ_TRUNC_BIT = 1;
  localparam int unsigned UDQ_BUS_WAIT_CYC = 1;

  // Byte offsets of the registers
  localparam logic [7:0] UDQ_OFF_RX0 = 8'h00;
  localparam logic [7:0] UDQ_OFF_RX1 = 8'h04;
  localparam logic [7:0] UDQ_OFF_RX2 = 8'h08;
  localparam logic [7:0] UDQ_OFF_RX3 = 8'h0c;
  localparam logic [7:0] UDQ_OFF_RX_STRIDE = 8'h04;
  localparam logic [7:0] UDQ_OFF_TX_W0 = 8'h10;
  localparam logic [7:0] UDQ_OFF_TX_W1 = 8'h14;
  localparam logic [7:0] UDQ_OFF_TX_W2 = 8'h18;
  localparam logic [7:0] UDQ_OFF_TX_W3 = 8'h1c;

  // Bits that software may change in each register
  localparam logic [31:0] UDQ_WMASK_RX = 32'h0000ffff;
  localparam logic [31:0] UDQ_WMASK_W01 = 32'hfffffffc;
  localparam logic [31:0] UDQ_WMASK_W2 = 32'hfffffffe;
  localparam logic [31:0] UDQ_WMASK_W3 = 32'hffffffff;

  localparam logic [15:0] UDQ_RST_TALLY = 16'h0000;
  localparam logic [29:0] UDQ_RST_PTR = 30'h00000000;
  localparam logic [31:0] UDQ_RST_BUFADDR = 32'h00000000;
  localparam logic [31:0] UDQ_RST_RDATA = 32'h00000000;

  typedef enum logic [2:0] {
    UDQ_UPD_RX_TAKE,
    UDQ_UPD_HEAD,
    UDQ_UPD_SOP,
    UDQ_UPD_CUR,
    UDQ_UPD_BUF,
    UDQ_UPD_EOP
  } udq_upd_e;

  typedef enum logic {
    UDQ_BUS_IDLE,
    UDQ_BUS_ACK
  } udq_bus_e;

  // One state update from the descriptor engine
  typedef struct packed {
    udq_upd_e kind;
    logic [1:0] chan;
    logic [31:0] value;
    logic trunc;
  } udq_upd_s;

  localparam int unsigned UDQ_UPD_W = $bits(udq_upd_s);

  typedef struct packed {
    logic [29:0] head_ptr;
    logic [29:0] sop_ptr;
    logic [29:0] cur_ptr;
    logic trunc;
    logic in_pkt;
    logic [31:0] buf_addr;
  } udq_tx_state_s;

  localparam udq_tx_state_s UDQ_RST_TX = '{
    head_ptr: UDQ_RST_PTR,
    sop_ptr: UDQ_RST_PTR,
    cur_ptr: UDQ_RST_PTR,
    trunc: 1'b0,
    in_pkt: 1'b0,
    buf_addr: UDQ_RST_BUFADDR
  };

endpackage : udq_pkg

// ---- verilog/udq_skid2.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset; the drain side may stall at will.
*/
`timescale 1ns/10ps
module udq_skid2
  import udq_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);

  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic wr_idx;
    logic rd_idx;
    logic [1:0] fill;
  } udq_skid_s;

  udq_skid_s st_ff;
  udq_skid_s nxt_st;
  logic push;
  logic pop;

  assign o_in_ready = (st_ff.fill != 2'd2);
  assign o_out_valid = (st_ff.fill != 2'd0);
  assign o_out_data = st_ff.slot[st_ff.rd_idx];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.slot[st_ff.wr_idx] = i_in_data;
      nxt_st.wr_idx = ~st_ff.wr_idx;
    end
    if (pop)
    begin
      nxt_st.rd_idx = ~st_ff.rd_idx;
    end
    nxt_st.fill = 2'(st_ff.fill + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  fill_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_ff.fill <= 2'd2) else $error("buffer fill above two");

endmodule : udq_skid2

// ---- verilog/udq_tally.sv ----
/*
  Queued buffer tally of one receive channel: software adds, the engine takes one at a time.
  Assumes software additions and engine takes come from the same clock domain.
*/
`timescale 1ns/10ps
module udq_tally
  import udq_pkg::*;
#(
  parameter int unsigned W = UDQ_TALLY_W
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_add_en,
  input wire logic [W-1:0] i_add_val,
  input wire logic i_take_en,
  output logic [W-1:0] o_count
);

  typedef struct packed {
    logic [W-1:0] count;
  } udq_tally_s;

  udq_tally_s st_ff;
  udq_tally_s nxt_st;
  logic [W-1:0] summed;

  assign o_count = st_ff.count;

  always_comb
  begin
    nxt_st = st_ff;
    summed = st_ff.count;
    if (i_add_en)
    begin
      summed = W'(st_ff.count + i_add_val);
    end
    // Taking from an empty queue holds at zero
    if (i_take_en && (summed != '0))
    begin
      summed = W'(summed - W'(1));
    end
    nxt_st.count = summed;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff.count <= W'(UDQ_RST_TALLY);
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  tally_add_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_add_en && !i_take_en) |=> (o_count == W'($past(o_count) + $past(i_add_val))))
    else $error("tally did not add the written value");

  tally_take_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_take_en && !i_add_en && (o_count != '0)) |=> (o_count == W'($past(o_count) - W'(1))))
    else $error("tally did not drop by one on take");

endmodule : udq_tally

// ---- verilog/udq_regs.sv ----
/*
  Register block for the packet DMA queue state: four receive buffer tallies and four
  transmit state words, reached over an Avalon-MM slave with waitrequest, and updated by
  the descriptor engine through a two-entry buffer.
  Assumes one clock, a synchronous active-low reset, and a master that holds each request
  until it sees waitrequest low.
*/
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module udq_regs
  import udq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [UDQ_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_upd_valid,
  input wire udq_upd_s i_upd,
  output logic o_upd_ready,
  output logic [UDQ_CHANS-1:0][UDQ_TALLY_W-1:0] o_rx_tally,
  output udq_tx_state_s o_tx_state
);

  typedef struct packed {
    udq_bus_e bus;
    logic [31:0] rdata;
    udq_tx_state_s tx;
  } udq_regs_s;

  udq_regs_s st_ff;
  udq_regs_s nxt_st;
  logic req;
  logic commit;
  logic wr_commit;
  logic [31:0] be_mask;
  logic buf_valid;
  logic buf_ready;
  logic [UDQ_UPD_W-1:0] buf_data;
  udq_upd_s upd;
  logic upd_fire;
  logic [UDQ_CHANS-1:0][UDQ_TALLY_W-1:0] tally;

  assign req = i_avs_read || i_avs_write;
  assign commit = (st_ff.bus == UDQ_BUS_ACK);
  assign wr_commit = commit && i_avs_write;
  assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign o_avs_waitrequest = !commit;
  assign o_avs_readdata = st_ff.rdata;
  assign o_tx_state = st_ff.tx;
  assign o_rx_tally = tally;

  // Engine updates wait while a software write is being committed
  assign buf_ready = !wr_commit;
  assign upd = udq_upd_s'(buf_data);
  assign upd_fire = buf_valid && buf_ready;

  udq_skid2 #(
    .W(UDQ_UPD_W)
  ) u_upd_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_upd_valid),
    .i_in_data(i_upd),
    .o_in_ready(o_upd_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_data),
    .i_out_ready(buf_ready)
  );

  genvar g;
  generate
    for (g = 0; g < UDQ_CHANS; g++)
    begin : g_chan
      localparam logic [7:0] OFF = UDQ_OFF_RX0 + 8'(g * UDQ_OFF_RX_STRIDE);
      logic add_en;
      logic take_en;
      assign add_en = wr_commit && (i_avs_address == OFF);
      assign take_en = upd_fire && (upd.kind == UDQ_UPD_RX_TAKE) && (upd.chan == 2'(g));
      udq_tally #(
        .W(UDQ_TALLY_W)
      ) u_tally (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_add_en(add_en),
        .i_add_val(UDQ_TALLY_W'(i_avs_writedata & be_mask & UDQ_WMASK_RX)),
        .i_take_en(take_en),
        .o_count(tally[g])
      );
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [31:0] mask);
    merge = (old & ~mask) | (wdata & mask);
  endfunction : merge

  function automatic logic [31:0] rd_word(input logic [7:0] addr,
                                          input udq_tx_state_s tx,
                                          input logic [UDQ_CHANS-1:0][15:0] cnt);
    rd_word = '0;
    unique case (addr)
      UDQ_OFF_RX0: rd_word = {16'h0000, cnt[0]};
      UDQ_OFF_RX1: rd_word = {16'h0000, cnt[1]};
      UDQ_OFF_RX2: rd_word = {16'h0000, cnt[2]};
      UDQ_OFF_RX3: rd_word = {16'h0000, cnt[3]};
      UDQ_OFF_TX_W0: rd_word = {tx.head_ptr, 1'b0, tx.in_pkt};
      UDQ_OFF_TX_W1: rd_word = {tx.sop_ptr, 1'b0, tx.in_pkt};
      UDQ_OFF_TX_W2: rd_word = {tx.cur_ptr, tx.trunc, 1'b0};
      UDQ_OFF_TX_W3: rd_word = tx.buf_addr;
      default: rd_word = '0;
    endcase
  endfunction : rd_word

  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff.bus)
      UDQ_BUS_IDLE:
      begin
        if (req)
        begin
          nxt_st.bus = UDQ_BUS_ACK;
          nxt_st.rdata = i_avs_read ? rd_word(i_avs_address, st_ff.tx, tally) : '0;
        end
      end
      UDQ_BUS_ACK:
      begin
        nxt_st.bus = UDQ_BUS_IDLE;
      end
    endcase
    if (wr_commit)
    begin
      unique case (i_avs_address)
        UDQ_OFF_TX_W0:
        begin
          nxt_st.tx.head_ptr = UDQ_PTR_W'(merge({st_ff.tx.head_ptr, 2'b00}, i_avs_writedata,
                                                be_mask & UDQ_WMASK_W01) >> UDQ_PTR_LSB);
        end
        UDQ_OFF_TX_W1:
        begin
          nxt_st.tx.sop_ptr = UDQ_PTR_W'(merge({st_ff.tx.sop_ptr, 2'b00}, i_avs_writedata,
                                               be_mask & UDQ_WMASK_W01) >> UDQ_PTR_LSB);
        end
        UDQ_OFF_TX_W2:
        begin
          nxt_st.tx.cur_ptr = UDQ_PTR_W'(merge({st_ff.tx.cur_ptr, 2'b00}, i_avs_writedata,
                                               be_mask & UDQ_WMASK_W2) >> UDQ_PTR_LSB);
          if (i_avs_byteenable[0])
          begin
            nxt_st.tx.trunc = i_avs_writedata[UDQ_TRUNC_BIT];
          end
        end
        UDQ_OFF_TX_W3:
        begin
          nxt_st.tx.buf_addr = merge(st_ff.tx.buf_addr, i_avs_writedata,
                                     be_mask & UDQ_WMASK_W3);
        end
        default:
        begin
          nxt_st.tx = st_ff.tx;
        end
      endcase
    end
    if (upd_fire)
    begin
      unique case (upd.kind)
        UDQ_UPD_HEAD: nxt_st.tx.head_ptr = upd.value[31:UDQ_PTR_LSB];
        UDQ_UPD_SOP:
        begin
          nxt_st.tx.sop_ptr = upd.value[31:UDQ_PTR_LSB];
          nxt_st.tx.in_pkt = 1'b1;
          nxt_st.tx.trunc = 1'b0;
        end
        UDQ_UPD_CUR:
        begin
          nxt_st.tx.cur_ptr = upd.value[31:UDQ_PTR_LSB];
          nxt_st.tx.trunc = upd.trunc;
        end
        UDQ_UPD_BUF: nxt_st.tx.buf_addr = upd.value;
        UDQ_UPD_EOP: nxt_st.tx.in_pkt = 1'b0;
        default: nxt_st.tx = nxt_st.tx;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff.bus <= UDQ_BUS_IDLE;
      st_ff.rdata <= UDQ_RST_RDATA;
      st_ff.tx <= UDQ_RST_TX;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_req_idle;
    req && (st_ff.bus == UDQ_BUS_IDLE);
  endsequence

  sequence s_read_done(logic [7:0] off);
    commit && i_avs_read && (i_avs_address == off);
  endsequence

  sequence s_upd(udq_upd_e k);
    upd_fire && (upd.kind == k);
  endsequence

  sequence s_no_eop;
    !(upd_fire && (upd.kind == UDQ_UPD_EOP));
  endsequence

  sequence s_write_done(logic [7:0] off);
    wr_commit && (i_avs_address == off);
  endsequence

  bus_answer_a: assert property (s_req_idle |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  rx_read_a: assert property (s_read_done(UDQ_OFF_RX2) |->
    (o_avs_readdata == {16'h0000, $past(tally[2])}))
    else $error("tally read wrong or upper bits set");

  head_upd_a: assert property (s_upd(UDQ_UPD_HEAD) |=>
    (o_tx_state.head_ptr == $past(upd.value[31:2])))
    else $error("head pointer not taken from engine");

  in_packet_a: assert property (s_upd(UDQ_UPD_SOP) ##1 s_no_eop[*2] |->
    o_tx_state.in_pkt)
    else $error("in-packet flag dropped before end of packet");

  pkt_end_a: assert property (s_upd(UDQ_UPD_EOP) |=> !o_tx_state.in_pkt)
    else $error("in-packet flag held after end of packet");

  w0_bits_a: assert property (s_read_done(UDQ_OFF_TX_W0) |->
    (o_avs_readdata[1:0] == {1'b0, $past(o_tx_state.in_pkt)}))
    else $error("word zero low bits wrong");

  sop_upd_a: assert property (s_upd(UDQ_UPD_SOP) |=>
    (o_tx_state.sop_ptr == $past(upd.value[31:2])) && o_tx_state.in_pkt)
    else $error("start pointer not taken from engine");

  cur_upd_a: assert property (s_upd(UDQ_UPD_CUR) |=>
    (o_tx_state.cur_ptr == $past(upd.value[31:2])) && (o_tx_state.trunc == $past(upd.trunc)))
    else $error("current descriptor or truncation not taken");

  w2_bits_a: assert property (s_read_done(UDQ_OFF_TX_W2) |->
    (o_avs_readdata[1:0] == {$past(o_tx_state.trunc), 1'b0}))
    else $error("word two low bits wrong");

  buf_upd_a: assert property (s_upd(UDQ_UPD_BUF) |=>
    (o_tx_state.buf_addr == $past(upd.value)))
    else $error("buffer address not taken from engine");

  unmapped_a: assert property (s_read_done(8'h20) |-> (o_avs_readdata == 32'h00000000))
    else $error("unmapped read not zero");

  rx_add_a: assert property (s_write_done(UDQ_OFF_RX1) |=>
    (o_rx_tally[1] == UDQ_TALLY_W'($past(o_rx_tally[1]) +
                                   $past(i_avs_writedata[15:0] & be_mask[15:0]))))
    else $error("tally write did not add");

  w1_write_a: assert property (s_write_done(UDQ_OFF_TX_W1) ##0 &i_avs_byteenable |=>
    (o_tx_state.sop_ptr == $past(i_avs_writedata[31:UDQ_PTR_LSB])))
    else $error("start pointer not written by software");

  w2_write_a: assert property (s_write_done(UDQ_OFF_TX_W2) ##0 i_avs_byteenable[0] |=>
    (o_tx_state.trunc == $past(i_avs_writedata[UDQ_TRUNC_BIT])))
    else $error("truncation flag not written by software");

  w3_write_a: assert property (s_write_done(UDQ_OFF_TX_W3) ##0 i_avs_byteenable[0] |=>
    (o_tx_state.buf_addr[7:0] == $past(i_avs_writedata[7:0])))
    else $error("buffer address low byte not written");

  inpkt_hold_a: assert property (wr_commit |=>
    (o_tx_state.in_pkt == $past(o_tx_state.in_pkt)))
    else $error("software write changed in-packet flag");

  stall_a: assert property (wr_commit |-> !upd_fire)
    else $error("engine update taken during software write");

endmodule : udq_regs

// ---- sim/tb_udq_regs.sv ----
/*
  Self-checking bench of the packet DMA queue state registers: reset values, tally
  additions and takes, transmit state words from engine and software, update bursts.
  Assumes the udq_regs top module, one 250 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module tb_udq_regs;
  import udq_pkg::*;
  logic i_clk;
  logic i_rst_n;
  logic [7:0] av_addr;
  logic av_rd;
  logic av_wr;
  logic [31:0] av_wdata;
  logic [3:0] av_be;
  logic [31:0] av_rdata;
  logic av_wait;
  logic upd_valid;
  udq_upd_s upd;
  logic upd_ready;
  logic [UDQ_CHANS-1:0][UDQ_TALLY_W-1:0] rx_tally;
  udq_tx_state_s tx_state;
  int err_count;
  int checks_done;
  int cycles;

  udq_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
    .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .i_upd_valid(upd_valid), .i_upd(upd), .o_upd_ready(upd_ready),
    .o_rx_tally(rx_tally), .o_tx_state(tx_state));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Cuts a hang short
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge i_clk);
    av_addr <= a;
    av_wdata <= d;
    av_be <= be;
    av_rd <= ~wr;
    av_wr <= wr;
    do @(posedge i_clk); while (av_wait !== 1'b0);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : bus

  task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wr32

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hf, q);
    chk(q, exp, msg);
  endtask : rd_chk

  task automatic send(input udq_upd_e k, input logic [1:0] c, input logic [31:0] v,
                      input logic t);
    @(posedge i_clk);
    upd_valid <= 1'b1;
    upd <= '{kind: k, chan: c, value: v, trunc: t};
    do @(posedge i_clk); while (upd_ready !== 1'b1);
    upd_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : send

  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask : do_reset

  task automatic t_reset_values();
    for (int i = 0; i < 8; i++)
      rd_chk(8'(i * 4), 32'h00000000, "reset value");
    rd_chk(8'h20, 32'h00000000, "unmapped read");
  endtask : t_reset_values

  task automatic t_tally_add();
    for (int c = 0; c < 4; c++)
    begin
      wr32(8'(c * 4), 32'(16'(c + 1) * 16'h0111), 4'hf);
      wr32(8'(c * 4), 32'(16'(c + 1) * 16'h0111), 4'hf);
      rd_chk(8'(c * 4), 32'(16'(c + 1) * 16'h0222), "tally sum");
    end
    // Upper half is reserved and the sum wraps in sixteen bits
    wr32(UDQ_OFF_RX3, 32'hfffffff0, 4'hf);
    rd_chk(UDQ_OFF_RX3, 32'h00000878, "tally wrap");
    chk(32'(rx_tally[3]), 32'h00000878, "tally port");
    wr32(UDQ_OFF_RX0, 32'h00000101, 4'h2);
    rd_chk(UDQ_OFF_RX0, 32'h00000322, "tally lane");
    wr32(8'h20, 32'hffffffff, 4'hf);
    rd_chk(8'h20, 32'h00000000, "unmapped write");
  endtask : t_tally_add

  // Five takes back to back while a software add commits on another channel
  task automatic t_take_burst();
    int taken;
    taken = 0;
    fork
      wr32(UDQ_OFF_RX2, 32'h00000001, 4'hf);
      begin
        @(posedge i_clk);
        upd_valid <= 1'b1;
        upd <= '{kind: UDQ_UPD_RX_TAKE, chan: 2'd1, value: 32'h0, trunc: 1'b0};
        while (taken < 5)
        begin
          @(posedge i_clk);
          if (upd_ready === 1'b1)
            taken++;
        end
        upd_valid <= 1'b0;
      end
    join
    repeat (6) @(posedge i_clk);
    rd_chk(UDQ_OFF_RX1, 32'h0000043f, "tally takes");
    rd_chk(UDQ_OFF_RX2, 32'h00000667, "add during takes");
  endtask : t_take_burst

  task automatic t_tx_engine();
    send(UDQ_UPD_SOP, 2'd0, 32'h20001004, 1'b0);
    send(UDQ_UPD_HEAD, 2'd0, 32'habcd000b, 1'b0);
    send(UDQ_UPD_CUR, 2'd0, 32'h00c0ffef, 1'b1);
    send(UDQ_UPD_BUF, 2'd0, 32'h89abcdef, 1'b0);
    rd_chk(UDQ_OFF_TX_W0, 32'habcd0009, "head word");
    rd_chk(UDQ_OFF_TX_W1, 32'h20001005, "packet start word");
    rd_chk(UDQ_OFF_TX_W2, 32'h00c0ffee, "descriptor word");
    rd_chk(UDQ_OFF_TX_W3, 32'h89abcdef, "buffer address");
    chk(tx_state.buf_addr, 32'h89abcdef, "buffer address port");
    send(UDQ_UPD_EOP, 2'd0, 32'h0, 1'b0);
    rd_chk(UDQ_OFF_TX_W0, 32'habcd0008, "head after packet");
    rd_chk(UDQ_OFF_TX_W1, 32'h20001004, "start after packet");
    send(UDQ_UPD_CUR, 2'd0, 32'h00000100, 1'b0);
    rd_chk(UDQ_OFF_TX_W2, 32'h00000100, "trunc cleared");
  endtask : t_tx_engine

  task automatic t_tx_software();
    wr32(UDQ_OFF_TX_W2, 32'hffffffff, 4'hf);
    rd_chk(UDQ_OFF_TX_W2, 32'hfffffffe, "descriptor write");
    wr32(UDQ_OFF_TX_W0, 32'hffffffff, 4'hf);
    rd_chk(UDQ_OFF_TX_W0, 32'hfffffffc, "head write");
    wr32(UDQ_OFF_TX_W1, 32'h12345677, 4'hf);
    rd_chk(UDQ_OFF_TX_W1, 32'h12345674, "start write");
    wr32(UDQ_OFF_TX_W3, 32'h00000055, 4'h1);
    rd_chk(UDQ_OFF_TX_W3, 32'h89abcd55, "buffer lane write");
  endtask : t_tx_software

  task automatic t_second_reset();
    do_reset();
    rd_chk(UDQ_OFF_TX_W2, 32'h00000000, "descriptor after reset");
    rd_chk(UDQ_OFF_RX1, 32'h00000000, "tally after reset");
  endtask : t_second_reset

  initial
  begin
    i_rst_n = 1'b0;
    av_addr = 8'h00;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h00000000;
    av_be = 4'h0;
    upd_valid = 1'b0;
    upd = '{kind: UDQ_UPD_RX_TAKE, chan: 2'd0, value: 32'h0, trunc: 1'b0};
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    do_reset();
    t_reset_values();
    t_tally_add();
    t_take_burst();
    t_tx_engine();
    t_tx_software();
    t_second_reset();
    complete_run();
  end
endmodule : tb_udq_regs
